// ==== tone_rx_defines.svh ====
/*
 * Constants of the tone-pair receiver: register offsets, field positions,
 * reset values, tone table and timing counts.
 * Assumes a 25 MHz pclk and is included by its bare name.
 */
`ifndef TONE_RX_DEFINES_SVH
`define TONE_RX_DEFINES_SVH

// Clock.
`define CLK_HZ            25000000
`define CLK_PERIOD_NS     40

// Register byte offsets on the APB.
`define ADDR_W            8
`define OFF_RX_DATA       8'h00
`define OFF_STATUS        8'h04
`define OFF_CTRL          8'h08
`define OFF_PRESENT_GUARD 8'h0c
`define OFF_ABSENT_GUARD  8'h10
`define OFF_INT_STATUS    8'h14
`define OFF_INT_MASK      8'h18

// Status register fields.
`define STAT_EARLY_BIT    0
`define STAT_STEER_BIT    1
`define STAT_VALID_BIT    2
`define STAT_DSTEER_BIT   3

// Control register fields.
`define CTRL_INT_MODE_BIT 0
`define CTRL_RST          1'h0

// Interrupt status and mask fields.
`define INT_W             3
`define INT_NEW_DATA_BIT  0
`define INT_TONE_ON_BIT   1
`define INT_TONE_OFF_BIT  2
`define INT_MASK_RST      3'h0

// Tone table in Hz, index order as used for decoding.
`define LOW_F0            697
`define LOW_F1            770
`define LOW_F2            852
`define LOW_F3            941
`define HIGH_F0           1209
`define HIGH_F1           1336
`define HIGH_F2           1477
`define HIGH_F3           1633
`define TOL_PCT           3
`define PER_W             17
`define PER_TIMEOUT_CYC   (`CLK_HZ / 600)

// Timing: figures in their own unit, cycle counts rounded up.
`define GUARD_W           24
`define SETTLE_NS         200
`define SETTLE_CYC        ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TONE_PRESENT_GUARD_US 20000
`define TONE_ABSENT_GUARD_US  20000
`define TONE_PRESENT_GUARD_CYC \
    ((`TONE_PRESENT_GUARD_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TONE_ABSENT_GUARD_CYC \
    ((`TONE_ABSENT_GUARD_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== tone_rx_pkg.sv ====
/*
 * Types shared by the tone-pair receiver files.
 * Assumes nothing of its surroundings.
 */
package tone_rx_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SETTLE,
        ST_HELD
    } steer_state_t;

    typedef logic [3:0] digit_code_t;

endpackage : tone_rx_pkg

// ==== tone_freq_counter.sv ====
/*
 * Measures the period of one hard-limited tone by counting pclk cycles
 * between rising edges and classifies it against the four group tones.
 * Assumes the tone input is asynchronous to pclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tone_rx_defines.svh"

module tone_freq_counter #(
    parameter int GROUP = 0
) (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       tone_in,
    output logic            tone_valid,
    output logic [1:0]      tone_idx
);

    function automatic int freq_of(input int g, input int i);
        case ({g[0], i[1:0]})
            3'b000:  freq_of = `LOW_F0;
            3'b001:  freq_of = `LOW_F1;
            3'b010:  freq_of = `LOW_F2;
            3'b011:  freq_of = `LOW_F3;
            3'b100:  freq_of = `HIGH_F0;
            3'b101:  freq_of = `HIGH_F1;
            3'b110:  freq_of = `HIGH_F2;
            default: freq_of = `HIGH_F3;
        endcase
    endfunction : freq_of

    logic [2:0]         sync_reg;
    logic [`PER_W-1:0]  per_reg,   per_next;
    logic [1:0]         last_reg,  last_next;
    logic               lok_reg,   lok_next;
    logic               valid_reg, valid_next;
    logic [1:0]         idx_reg,   idx_next;
    logic               rise;
    logic               match;
    logic [1:0]         cand;

    assign rise = sync_reg[1] & ~sync_reg[2];

    always_comb begin
        int p;
        int nom;
        p          = int'(per_reg);
        nom        = 0;
        match      = 1'b0;
        cand       = 2'd0;
        per_next   = per_reg;
        last_next  = last_reg;
        lok_next   = lok_reg;
        valid_next = valid_reg;
        idx_next   = idx_reg;
        for (int i = 0; i < 4; i++) begin
            nom = `CLK_HZ / freq_of(GROUP, i);
            if (p >= nom * 100 / (100 + `TOL_PCT) &&
                p <= nom * 100 / (100 - `TOL_PCT)) begin
                match = 1'b1;
                cand  = 2'(i);
            end
        end
        // Two matching periods in a row are needed, a light averaging
        // that keeps voice bursts from passing as tones.
        if (rise) begin
            valid_next = match && lok_reg && (cand == last_reg);
            idx_next   = cand;
            last_next  = cand;
            lok_next   = match;
            per_next   = `PER_W'(1);
        end else if (p >= `PER_TIMEOUT_CYC) begin
            valid_next = 1'b0;
            lok_next   = 1'b0;
        end else begin
            per_next = per_reg + `PER_W'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_reg  <= 3'h0;
            per_reg   <= '0;
            last_reg  <= 2'h0;
            lok_reg   <= 1'b0;
            valid_reg <= 1'b0;
            idx_reg   <= 2'h0;
        end else begin
            sync_reg  <= {sync_reg[1:0], tone_in};
            per_reg   <= per_next;
            last_reg  <= last_next;
            lok_reg   <= lok_next;
            valid_reg <= valid_next;
            idx_reg   <= idx_next;
        end
    end

    assign tone_valid = valid_reg;
    assign tone_idx   = idx_reg;

endmodule : tone_freq_counter
`default_nettype wire

// ==== tone_guard_timer.sv ====
/*
 * Replaces the external steering RC: the steer level follows early
 * detect only after it has held its new state for the guard count.
 * Assumes early detect and the limits come from the pclk domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "tone_rx_defines.svh"

module tone_guard_timer (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 early_tone_detect,
    input  wire logic [`GUARD_W-1:0]  present_limit,
    input  wire logic [`GUARD_W-1:0]  absent_limit,
    output logic                      steer
);

    logic [`GUARD_W-1:0] cnt_reg,   cnt_next;
    logic                steer_reg, steer_next;
    logic [`GUARD_W-1:0] limit;

    assign limit = early_tone_detect ? present_limit : absent_limit;

    always_comb begin
        cnt_next   = '0;
        steer_next = steer_reg;
        // Any return of early detect to the steer level restarts the count.
        if (early_tone_detect != steer_reg) begin
            if (cnt_reg + `GUARD_W'(1) >= limit) begin
                steer_next = early_tone_detect;
            end else begin
                cnt_next = cnt_reg + `GUARD_W'(1);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_reg   <= '0;
            steer_reg <= 1'b0;
        end else begin
            cnt_reg   <= cnt_next;
            steer_reg <= steer_next;
        end
    end

    assign steer = steer_reg;

endmodule : tone_guard_timer
`default_nettype wire

// ==== tone_pair_receiver_steering.sv ====
/*
 * Digital back end of a dual-tone receiver: period counting of both
 * limited tone groups, early detect, guard-time steering, code latch,
 * delayed steering, open-drain interrupt and an APB register slave.
 * Assumes the two tone inputs come from comparators, asynchronous to
 * pclk, and that an APB master on pclk reaches the registers.
 */
// The APB interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tone_rx_defines.svh"

module tone_pair_receiver_steering #(
    parameter logic [`GUARD_W-1:0] PRESENT_GUARD_CYC = `GUARD_W'(`TONE_PRESENT_GUARD_CYC),
    parameter logic [`GUARD_W-1:0] ABSENT_GUARD_CYC  = `GUARD_W'(`TONE_ABSENT_GUARD_CYC)
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [`ADDR_W-1:0] paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic               low_group_tone,
    input  wire logic               high_group_tone,
    output logic                    early_tone_detect,
    output logic                    guard_time_drive,
    output logic                    irq_or_progress_out,
    output logic                    irq_or_progress_oe,
    output logic                    irq
);

    ////////////////////////////////////////////////////////////////////////
    // Frequency measurement of both tone groups.

    logic [1:0] tone_in;
    logic [1:0] grp_valid;
    logic [1:0] grp_idx [2];

    assign tone_in = {high_group_tone, low_group_tone};

    for (genvar g = 0; g < 2; g++) begin : g_group
        tone_freq_counter #(
            .GROUP      (g)
        ) u_counter (
            .pclk       (pclk),
            .presetn    (presetn),
            .tone_in    (tone_in[g]),
            .tone_valid (grp_valid[g]),
            .tone_idx   (grp_idx[g])
        );
    end

    // Both groups valid is the signal condition; losing either drops it.
    assign early_tone_detect = grp_valid[0] & grp_valid[1];

    ////////////////////////////////////////////////////////////////////////
    // Pair to code mapping.

    function automatic tone_rx_pkg::digit_code_t pair_code(input logic [1:0] lo,
                                                           input logic [1:0] hi);
        if (hi == 2'd3) begin
            pair_code = (lo == 2'd3) ? 4'h0 : 4'(4'hd + {2'b00, lo});
        end else if (lo == 2'd3) begin
            case (hi)
                2'd0:    pair_code = 4'hb;
                2'd1:    pair_code = 4'ha;
                default: pair_code = 4'hc;
            endcase
        end else begin
            pair_code = 4'({2'b00, lo} * 4'h3 + {2'b00, hi} + 4'h1);
        end
    endfunction : pair_code

    ////////////////////////////////////////////////////////////////////////
    // Guard-time steering.

    logic [`GUARD_W-1:0] present_guard_reg, present_guard_next;
    logic [`GUARD_W-1:0] absent_guard_reg,  absent_guard_next;
    logic                steer;

    tone_guard_timer u_guard (
        .pclk              (pclk),
        .presetn           (presetn),
        .early_tone_detect (early_tone_detect),
        .present_limit     (present_guard_reg),
        .absent_limit      (absent_guard_reg),
        .steer             (steer)
    );

    // Guard drive holds the steering node up while the tone persists,
    // so a registered pair cannot be registered twice.
    assign guard_time_drive = steer & early_tone_detect;

    ////////////////////////////////////////////////////////////////////////
    // Steering state, code latch and delayed steering.

    tone_rx_pkg::steer_state_t state_reg, state_next;
    logic                      steer_d_reg;
    logic                      steer_rise;
    logic                      steer_fall;
    logic [2:0]                settle_reg, settle_next;
    tone_rx_pkg::digit_code_t  code_reg,   code_next;
    tone_rx_pkg::digit_code_t  out_reg,    out_next;
    logic                      dsteer_reg, dsteer_next;
    logic                      dsteer_rise;

    assign steer_rise = steer & ~steer_d_reg;
    assign steer_fall = ~steer & steer_d_reg;

    always_comb begin
        state_next  = state_reg;
        settle_next = settle_reg;
        code_next   = code_reg;
        out_next    = out_reg;
        dsteer_next = dsteer_reg;
        dsteer_rise = 1'b0;
        case (state_reg)
            tone_rx_pkg::ST_IDLE: begin
                if (steer_rise) begin
                    code_next   = pair_code(grp_idx[0], grp_idx[1]);
                    settle_next = 3'h0;
                    state_next  = tone_rx_pkg::ST_SETTLE;
                end
            end
            tone_rx_pkg::ST_SETTLE: begin
                if (!steer) begin
                    state_next = tone_rx_pkg::ST_IDLE;
                end else if (settle_reg >= 3'(`SETTLE_CYC - 1)) begin
                    dsteer_next = 1'b1;
                    dsteer_rise = 1'b1;
                    out_next    = code_reg;
                    state_next  = tone_rx_pkg::ST_HELD;
                end else begin
                    settle_next = settle_reg + 3'h1;
                end
            end
            tone_rx_pkg::ST_HELD: begin
                // Short dropouts never reach here: the absent guard hides them.
                if (steer_fall) begin
                    dsteer_next = 1'b0;
                    state_next  = tone_rx_pkg::ST_IDLE;
                end
            end
            default: begin
                dsteer_next = 1'b0;
                state_next  = tone_rx_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg   <= tone_rx_pkg::ST_IDLE;
            steer_d_reg <= 1'b0;
            settle_reg  <= 3'h0;
            code_reg    <= 4'h0;
            out_reg     <= 4'h0;
            dsteer_reg  <= 1'b0;
        end else begin
            state_reg   <= state_next;
            steer_d_reg <= steer;
            settle_reg  <= settle_next;
            code_reg    <= code_next;
            out_reg     <= out_next;
            dsteer_reg  <= dsteer_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // APB decode.

    logic setup_ph;
    logic access_ph;
    logic wr_en;
    logic rd_status;
    logic mapped;

    assign setup_ph  = psel & ~penable;
    assign access_ph = psel & penable;
    assign wr_en     = access_ph & pwrite;
    assign rd_status = access_ph & ~pwrite & (paddr == `OFF_STATUS);

    always_comb begin
        case (paddr)
            `OFF_RX_DATA, `OFF_STATUS, `OFF_CTRL, `OFF_PRESENT_GUARD,
            `OFF_ABSENT_GUARD, `OFF_INT_STATUS, `OFF_INT_MASK: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    assign pready  = 1'b1;
    assign pslverr = access_ph & ~mapped;

    ////////////////////////////////////////////////////////////////////////
    // Control, data-valid and interrupt state.

    logic              int_mode_reg, int_mode_next;
    logic              valid_reg,    valid_next;
    logic              irq_pend_reg, irq_pend_next;
    logic              seen_reg,     seen_next;
    logic [`INT_W-1:0] int_stat_reg, int_stat_next;
    logic [`INT_W-1:0] int_mask_reg, int_mask_next;
    logic [`INT_W-1:0] int_events;
    logic [31:0]       rdata_reg,    rdata_next;
    logic [31:0]       status_word;

    assign int_events = {steer_fall, steer_rise, dsteer_rise};

    always_comb begin
        status_word                   = 32'h0;
        status_word[`STAT_EARLY_BIT]  = early_tone_detect;
        status_word[`STAT_STEER_BIT]  = steer;
        status_word[`STAT_VALID_BIT]  = valid_reg;
        status_word[`STAT_DSTEER_BIT] = dsteer_reg;
    end

    always_comb begin
        int_mode_next      = int_mode_reg;
        present_guard_next = present_guard_reg;
        absent_guard_next  = absent_guard_reg;
        int_mask_next      = int_mask_reg;
        int_stat_next      = int_stat_reg;
        valid_next         = valid_reg;
        irq_pend_next      = irq_pend_reg;
        seen_next          = seen_reg;
        rdata_next         = rdata_reg;
        // Read data is taken in the setup cycle and shown in the access cycle.
        if (setup_ph) begin
            case (paddr)
                `OFF_RX_DATA:       rdata_next = {28'h0, out_reg};
                `OFF_STATUS:        rdata_next = status_word;
                `OFF_CTRL:          rdata_next = {31'h0, int_mode_reg};
                `OFF_PRESENT_GUARD: rdata_next = {8'h0, present_guard_reg};
                `OFF_ABSENT_GUARD:  rdata_next = {8'h0, absent_guard_reg};
                `OFF_INT_STATUS:    rdata_next = {29'h0, int_stat_reg};
                `OFF_INT_MASK:      rdata_next = {29'h0, int_mask_reg};
                default:            rdata_next = 32'h0;
            endcase
            seen_next = valid_reg;
        end
        if (wr_en) begin
            case (paddr)
                `OFF_CTRL:          int_mode_next = pwdata[`CTRL_INT_MODE_BIT];
                `OFF_PRESENT_GUARD: present_guard_next = pwdata[`GUARD_W-1:0];
                `OFF_ABSENT_GUARD:  absent_guard_next = pwdata[`GUARD_W-1:0];
                `OFF_INT_STATUS:    int_stat_next = int_stat_reg & ~pwdata[`INT_W-1:0];
                `OFF_INT_MASK:      int_mask_next = pwdata[`INT_W-1:0];
                default: ;
            endcase
        end
        // Only a flag the host has actually seen is cleared, so an event
        // between the setup and the access cycle is not lost.
        if (rd_status && seen_reg) begin
            valid_next    = 1'b0;
            irq_pend_next = 1'b0;
        end
        if (dsteer_rise) begin
            valid_next    = 1'b1;
            irq_pend_next = 1'b1;
        end
        int_stat_next = int_stat_next | int_events;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mode_reg      <= `CTRL_RST;
            present_guard_reg <= PRESENT_GUARD_CYC;
            absent_guard_reg  <= ABSENT_GUARD_CYC;
            int_mask_reg      <= `INT_MASK_RST;
            int_stat_reg      <= '0;
            valid_reg         <= 1'b0;
            irq_pend_reg      <= 1'b0;
            seen_reg          <= 1'b0;
            rdata_reg         <= 32'h0;
        end else begin
            int_mode_reg      <= int_mode_next;
            present_guard_reg <= present_guard_next;
            absent_guard_reg  <= absent_guard_next;
            int_mask_reg      <= int_mask_next;
            int_stat_reg      <= int_stat_next;
            valid_reg         <= valid_next;
            irq_pend_reg      <= irq_pend_next;
            seen_reg          <= seen_next;
            rdata_reg         <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign prdata = rdata_reg;

    // The pin only ever pulls low; the board pull-up gives the high level.
    assign irq_or_progress_out = 1'b0;
    assign irq_or_progress_oe  = int_mode_reg & irq_pend_reg & dsteer_reg;

    assign irq = |(int_stat_reg & int_mask_reg);

endmodule : tone_pair_receiver_steering
`default_nettype wire

// ==== tone_rx_asserts.sv ====
/* Port-level checker for the tone receiver top.
   Assumes one pclk domain and the small guard parameter of the bench. */
`timescale 1ns/1ps
`default_nettype none
`include "tone_rx_defines.svh"
module tone_rx_checker #(
    parameter logic [`GUARD_W-1:0] PRESENT_GUARD_CYC = `GUARD_W'(20)
) (
    input wire logic               pclk,
    input wire logic               presetn,
    input wire logic               psel,
    input wire logic               penable,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [31:0]        prdata,
    input wire logic               pready,
    input wire logic               pslverr,
    input wire logic               early_tone_detect,
    input wire logic               guard_time_drive,
    input wire logic               irq_or_progress_out,
    input wire logic               irq_or_progress_oe,
    input wire logic               irq
);
    logic [`GUARD_W-1:0] early_cnt_reg;
    logic [`GUARD_W-1:0] early_cnt_next;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Counts how long early detect has been high without a break.
    always_comb early_cnt_next = early_tone_detect ? early_cnt_reg + 1'b1 : '0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) early_cnt_reg <= '0;
        else early_cnt_reg <= early_cnt_next;
    end
    ////////////////////////////////////////////////////////////////////////
    property p_guard_needs_early; guard_time_drive |-> early_tone_detect; endproperty
    a_guard_needs_early: assert property (p_guard_needs_early)
        else $error("guard drive high without early detect");
    property p_guard_holds; guard_time_drive ##1 early_tone_detect |-> guard_time_drive;
    endproperty
    a_guard_holds: assert property (p_guard_holds)
        else $error("guard drive dropped while early detect held");
    property p_guard_after_hold;
        $rose(guard_time_drive) && $past(early_tone_detect) |->
            early_cnt_reg >= PRESENT_GUARD_CYC - 2'd2;
    endproperty
    a_guard_after_hold: assert property (p_guard_after_hold)
        else $error("guard drive rose before the present guard time");
    property p_guard_in_time; early_cnt_reg == PRESENT_GUARD_CYC + 2'd2 |-> guard_time_drive;
    endproperty
    a_guard_in_time: assert property (p_guard_in_time)
        else $error("guard drive late after the present guard time");
    property p_pin_low; !irq_or_progress_out; endproperty
    a_pin_low: assert property (p_pin_low)
        else $error("open drain pin drives high");
    property p_ready; psel && penable |-> pready; endproperty
    a_ready: assert property (p_ready)
        else $error("no ready in access phase");
    property p_err_access; pslverr |-> psel && penable; endproperty
    a_err_access: assert property (p_err_access)
        else $error("slave error outside access phase");
    property p_unmapped; psel && penable && paddr > 8'h18 |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");
    property p_reset_quiet; $rose(presetn) |-> !irq && !irq_or_progress_oe && !guard_time_drive;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("outputs active just after reset");
    c_guard: cover property ($rose(guard_time_drive));
    c_pin: cover property ($rose(irq_or_progress_oe));
    c_err: cover property (pslverr);
endmodule : tone_rx_checker
bind tone_pair_receiver_steering tone_rx_checker #(.PRESENT_GUARD_CYC(PRESENT_GUARD_CYC))
    tone_rx_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .early_tone_detect(early_tone_detect), .guard_time_drive(guard_time_drive),
    .irq_or_progress_out(irq_or_progress_out), .irq_or_progress_oe(irq_or_progress_oe),
    .irq(irq));
`default_nettype wire

// ==== tone_line_model.sv ====
/* Line side: two limited tones as square waves, 0 Hz holds the level.
   Assumes the bench changes frequencies by non-blocking assignment. */
`timescale 1ns/1ps
`default_nettype none
module tone_line_model (
    input wire logic pclk,
    input var int    low_hz,
    input var int    high_hz,
    output logic     low_group_tone,
    output logic     high_group_tone
);
    int lc;
    int hc;
    initial begin
        low_group_tone = 1'b0;
        high_group_tone = 1'b0;
        lc = 0;
        hc = 0;
    end
    always @(posedge pclk) begin
        lc <= (low_hz == 0 || lc >= 12500000 / low_hz - 1) ? 0 : lc + 1;
        hc <= (high_hz == 0 || hc >= 12500000 / high_hz - 1) ? 0 : hc + 1;
        if (low_hz != 0 && lc >= 12500000 / low_hz - 1) low_group_tone <= !low_group_tone;
        if (high_hz != 0 && hc >= 12500000 / high_hz - 1) high_group_tone <= !high_group_tone;
    end
endmodule : tone_line_model
`default_nettype wire

// ==== tb_tone_pair_receiver_steering.sv ====
/* Self-checking bench: APB master, tone line model, code table model.
   Assumes the receiver built with guard counts of 20 cycles. */
`timescale 1ns/1ps
`default_nettype none
`include "tone_rx_defines.svh"
module tb_tone_pair_receiver_steering;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [`ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd, m;
    logic low_group_tone, high_group_tone, early_tone_detect, guard_time_drive;
    logic irq_or_progress_out, irq_or_progress_oe, irq;
    int low_hz, high_hz, miscompares, tests_run, cycles, exp_int;
    int lo_f [4] = '{697, 770, 852, 941};
    int hi_f [4] = '{1209, 1336, 1477, 1633};
    int code_tab [16] = '{1, 2, 3, 13, 4, 5, 6, 14, 7, 8, 9, 15, 11, 10, 12, 0};
    tone_pair_receiver_steering #(.PRESENT_GUARD_CYC(24'd20), .ABSENT_GUARD_CYC(24'd20))
        tone_pair_receiver_steering_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .low_group_tone(low_group_tone),
        .high_group_tone(high_group_tone), .early_tone_detect(early_tone_detect),
        .guard_time_drive(guard_time_drive), .irq_or_progress_out(irq_or_progress_out),
        .irq_or_progress_oe(irq_or_progress_oe), .irq(irq));
    tone_line_model tone_line_model_i (.pclk(pclk), .low_hz(low_hz), .high_hz(high_hz),
        .low_group_tone(low_group_tone), .high_group_tone(high_group_tone));
    ////////////////////////////////////////////////////////////////////////
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask : apb
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk
    task automatic complete_run;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : complete_run
    // One digit: tones on, wait for the interrupt, then read and clear.
    task automatic play(input int li, input int hi);
        int n;
        low_hz <= lo_f[li];
        high_hz <= hi_f[hi];
        for (n = 0; n < 90000 && irq !== 1'b1; n++) @(posedge pclk);
        chk("pin_oe", 1, irq_or_progress_oe);
        chk("guard", 1, guard_time_drive);
        apb(1'b0, `OFF_RX_DATA, 0); chk("rx_data", 32'(code_tab[li * 4 + hi]), rd);
        apb(1'b0, `OFF_STATUS, 0); chk("status", 32'hf, rd);
        @(negedge pclk) chk("pin_oe_read", 0, irq_or_progress_oe);
        apb(1'b0, `OFF_STATUS, 0); chk("status_again", 32'hb, rd);
        apb(1'b0, `OFF_INT_STATUS, 0); chk("int_status", 32'(exp_int), rd);
        apb(1'b1, `OFF_INT_STATUS, 32'h7);
        @(negedge pclk) chk("irq_clear", 0, irq);
    endtask : play
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 250000) begin
            miscompares++;
            complete_run;
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {low_hz, high_hz, miscompares, tests_run, cycles} = '0;
        void'($urandom(8));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `OFF_RX_DATA, 0); chk("rx_reset", 0, rd);
        apb(1'b0, `OFF_STATUS, 0); chk("status_reset", 0, rd);
        apb(1'b0, `OFF_INT_MASK, 0); chk("mask_reset", 0, rd);
        apb(1'b0, 8'h1c, 0); chk("unmapped_err", 1, err);
        m = $urandom & 32'h7;
        apb(1'b1, `OFF_INT_MASK, m);
        apb(1'b0, `OFF_INT_MASK, 0); chk("mask", m, rd);
        apb(1'b1, `OFF_PRESENT_GUARD, 32'd20);
        apb(1'b0, `OFF_PRESENT_GUARD, 0); chk("present_guard", 32'd20, rd);
        apb(1'b1, `OFF_CTRL, 32'h1);
        apb(1'b1, `OFF_INT_MASK, 32'h1);
        exp_int = 3;
        play(3, 0);
        exp_int = 7;
        play(3, 3);
        // An off-table low tone must drop early detect and free the steering.
        low_hz <= 1000;
        for (int n = 0; n < 40000 && early_tone_detect !== 1'b0; n++) @(posedge pclk);
        @(negedge pclk) chk("guard_off", 0, guard_time_drive);
        repeat (30) @(posedge pclk);
        apb(1'b0, `OFF_STATUS, 0); chk("status_idle", 0, rd);
        apb(1'b0, `OFF_RX_DATA, 0); chk("rx_kept", 0, rd);
        complete_run;
    end
endmodule : tb_tone_pair_receiver_steering
`default_nettype wire
